/* design/pmr_pkg.sv */
// Package with register addresses, field positions and reset values of the management map.
package pmr_pkg;
  localparam logic [4:0] ADDR_BASIC_CONTROL      = 5'h00;
  localparam logic [4:0] ADDR_BASIC_STATUS       = 5'h01;
  localparam logic [4:0] ADDR_IDENTIFIER_HIGH    = 5'h02;
  localparam logic [4:0] ADDR_IDENTIFIER_LOW     = 5'h03;
  localparam logic [4:0] ADDR_NEG_ADVERTISE      = 5'h04;
  localparam logic [4:0] ADDR_PARTNER_ABILITY    = 5'h05;
  localparam logic [4:0] ADDR_NEG_EXPANSION      = 5'h06;
  localparam logic [4:0] ADDR_NEG_NEXT_PAGE      = 5'h07;
  localparam logic [4:0] ADDR_PARTNER_NEXT_PAGE  = 5'h08;
  localparam logic [4:0] ADDR_MAC_IF_CONTROL     = 5'h14;
  localparam logic [4:0] ADDR_RX_ERROR_TALLY     = 5'h15;
  localparam logic [4:0] ADDR_IRQ_CONTROL_STATUS = 5'h1b;
  localparam logic [4:0] ADDR_VENDOR_CONTROL_ONE = 5'h1e;
  localparam logic [4:0] ADDR_VENDOR_CONTROL_TWO = 5'h1f;

  // Bit positions within the basic control register.
  localparam int BIT_SOFT_RESET    = 15;
  localparam int BIT_LOOPBACK      = 14;
  localparam int BIT_SPEED         = 13;
  localparam int BIT_NEG_ENABLE    = 12;
  localparam int BIT_POWER_DOWN    = 11;
  localparam int BIT_ISOLATE       = 10;
  localparam int BIT_RESTART_NEG   = 9;
  localparam int BIT_DUPLEX        = 8;
  localparam int BIT_COL_TEST      = 7;
  localparam int BIT_TX_DISABLE    = 0;

  // Writable bits of the basic control register; reserved bits 6:1 excluded.
  localparam logic [15:0] CTRL_WRITE_MASK  = 16'hff81;
  // Reset value of the plain writable registers.
  localparam logic [15:0] PLAIN_RESET      = 16'h0000;
  // Arbitrary neutral identity values.
  localparam logic [15:0] ID_HIGH_VALUE    = 16'h1234;
  localparam logic [15:0] ID_LOW_VALUE     = 16'h5670;
  // Fixed status content: abilities, preamble suppression, negotiation ability, extended.
  localparam logic [15:0] STATUS_FIXED     = 16'h7849;
  localparam int          STATUS_NEG_DONE  = 5;
  localparam int          STATUS_LINK      = 2;
  // Cycles the internal soft reset pulse lasts before the bit self-clears.
  localparam int          SOFT_RESET_CYCLES = 4;
endpackage

/* design/pmr_strap_latch.sv */
// Strap capture that holds the pin levels seen during the hardware reset.
`timescale 1ns/1ns
module pmr_strap_latch
  import pmr_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset_req,
  input  wire logic speed_strap,
  input  wire logic autoneg_strap_input,
  input  wire logic isolate_strap,
  input  wire logic duplex_strap,
  output logic      speed_def,
  output logic      neg_def,
  output logic      iso_def,
  output logic      dup_def
);
  logic [3:0] strap_ff;

  // Pin levels are captured while the hardware reset is held, so a later soft reset reloads
  // the power-up straps even if a board reuses those pins afterwards.
  always_ff @(posedge mclk)
  begin
    if (reset_req)
      strap_ff <= {speed_strap, autoneg_strap_input, isolate_strap, duplex_strap};
  end

  // Pins pass straight through during the hardware reset, so its first edge already sees them.
  always_comb
  begin
    if (reset_req)
    begin
      speed_def = speed_strap;
      neg_def   = autoneg_strap_input;
      iso_def   = isolate_strap;
      dup_def   = ~duplex_strap;     // RULE_06
    end
    else
    begin
      speed_def = strap_ff[3];
      neg_def   = strap_ff[2];
      iso_def   = strap_ff[1];
      dup_def   = ~strap_ff[0];      // RULE_06
    end
  end
endmodule

/* design/pmr_sc_pulse.sv */
// Counter that stretches a soft reset request into a fixed length pulse.
`timescale 1ns/1ns
module pmr_sc_pulse
  import pmr_pkg::*;
#(
  parameter int CYCLES = SOFT_RESET_CYCLES
)
(
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic start,
  output logic      busy
);
  // Refuse pulse lengths that the eight-bit counter cannot hold.
  if (CYCLES < 1 || CYCLES > 255)
  begin
    $error("CYCLES out of range");
  end
  logic [7:0] cnt_ff;
  // Counts down after a start; busy holds while nonzero.
  always_ff @(posedge mclk)
  begin
    if (srst)
      cnt_ff <= 8'h00;
    else if (start)
      cnt_ff <= 8'(CYCLES);
    else if (cnt_ff != 8'h00)
      cnt_ff <= cnt_ff - 8'h01;
  end
  assign busy = (cnt_ff != 8'h00);
endmodule

/* design/pmr_regmap.sv */
// Management register map with the basic control register and its mode outputs.
//
// Operation
// RULE_01: Writing one to reset bit starts transceiver reset, bit self-clears.
// RULE_02: Loopback bit routes transmit data back internally; resets to zero.
// RULE_03: Speed bit picks 100 or 10 Mb/s, ignored while negotiation enabled.
// RULE_04: Negotiation enable runs negotiation, outcome overrides manual speed and duplex.
// RULE_05: Speed, negotiation enable and isolate bits load from strap pins.
// RULE_06: Duplex bit resets to the inverse of the duplex strap.
// RULE_07: Power-down bit enters power-down mode; resets to zero.
// RULE_08: Power-down disables everything except the management interface.
// RULE_09: Isolate bit isolates from MAC interface and line transmitter.
// RULE_10: Restart bit restarts negotiation, then self-clears; resets to zero.
// RULE_11: Without negotiation, duplex bit selects full or half duplex.
// RULE_12: Collision test bit enables the collision output test.
// RULE_13: Transmitter disable bit turns the line transmitter off when one.
// RULE_14: Decode the fourteen defined register addresses.
// RULE_15: Gaps between defined registers are reserved.
// RULE_16: Reserved control bits and reserved addresses read zero, ignore writes.
// RULE_17: Software reset returns writable registers to defaults before self-clear.
`timescale 1ns/1ns
module pmr_regmap
  import pmr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata,
  input  wire logic        speed_strap,
  input  wire logic        autoneg_strap_input,
  input  wire logic        isolate_strap,
  input  wire logic        duplex_strap,
  input  wire logic        neg_done,
  input  wire logic        neg_speed_100,
  input  wire logic        neg_full_duplex,
  input  wire logic        link_up,
  input  wire logic [15:0] partner_ability,
  input  wire logic [15:0] neg_expansion,
  input  wire logic [15:0] partner_next_page,
  input  wire logic        rx_error_event,
  output logic             phy_reset,
  output logic             neg_enable,
  output logic             neg_restart,
  output logic             speed_100,
  output logic             full_duplex,
  output logic             loopback_en,
  output logic             power_down,
  output logic             func_enable,
  output logic             isolate_en,
  output logic             col_test_en,
  output logic             tx_enable
);
  logic [15:0] ctrl_ff;
  logic [15:0] adv_ff;
  logic [15:0] np_ff;
  logic [15:0] mac_ctl_ff;
  logic [15:0] err_cnt_ff;
  logic [15:0] irq_ff;
  logic [15:0] vc1_ff;
  logic [15:0] vc2_ff;
  logic        restart_ff;
  logic        speed_def;
  logic        neg_def;
  logic        iso_def;
  logic        dup_def;
  logic        soft_start;
  logic        soft_busy;
  logic        any_reset;

  // Helper decoding a write to one address.
  function automatic logic wr_hit(input logic [4:0] a);
    return reg_wr && (reg_addr == a);
  endfunction

  pmr_strap_latch u_strap (
    .mclk                (mclk),
    .reset_req           (srst),
    .speed_strap         (speed_strap),
    .autoneg_strap_input (autoneg_strap_input),
    .isolate_strap       (isolate_strap),
    .duplex_strap        (duplex_strap),
    .speed_def           (speed_def),
    .neg_def             (neg_def),
    .iso_def             (iso_def),
    .dup_def             (dup_def)
  );

  // A one written to the reset bit launches the internal reset pulse.
  assign soft_start = wr_hit(ADDR_BASIC_CONTROL) && reg_wdata[BIT_SOFT_RESET];  // RULE_01

  pmr_sc_pulse #(.CYCLES(SOFT_RESET_CYCLES)) u_pulse (
    .mclk  (mclk),
    .srst  (srst),
    .start (soft_start),
    .busy  (soft_busy)
  );

  // Registers reload during the whole pulse, so defaults are in place before self-clear.
  assign any_reset = srst || soft_busy;  // RULE_17

  // Basic control register; strap defaults loaded on every reset.
  always_ff @(posedge mclk)
  begin
    if (any_reset)
    begin
      ctrl_ff                 <= PLAIN_RESET;
      ctrl_ff[BIT_SPEED]      <= speed_def;  // RULE_05
      ctrl_ff[BIT_NEG_ENABLE] <= neg_def;    // RULE_05
      ctrl_ff[BIT_ISOLATE]    <= iso_def;    // RULE_05
      ctrl_ff[BIT_DUPLEX]     <= dup_def;    // RULE_06
      // The reset bit is not stored; it reads the pulse counter and so clears with the pulse.
    end
    else if (wr_hit(ADDR_BASIC_CONTROL))
    begin
      // Reserved bits are masked off; self-clearing bits do not store here.
      ctrl_ff                  <= reg_wdata & CTRL_WRITE_MASK;  // RULE_16
      ctrl_ff[BIT_SOFT_RESET]  <= 1'b0;
      ctrl_ff[BIT_RESTART_NEG] <= 1'b0;
    end
  end

  // Restart pulse reads back as one for a single cycle, then self-clears.
  always_ff @(posedge mclk)
  begin
    if (any_reset)
      restart_ff <= 1'b0;
    else
      restart_ff <= wr_hit(ADDR_BASIC_CONTROL) && reg_wdata[BIT_RESTART_NEG];  // RULE_10
  end

  // Other writable registers, kept as plain storage.
  always_ff @(posedge mclk)
  begin
    if (any_reset)
    begin
      adv_ff     <= PLAIN_RESET;
      np_ff      <= PLAIN_RESET;
      mac_ctl_ff <= PLAIN_RESET;
      irq_ff     <= PLAIN_RESET;
      vc1_ff     <= PLAIN_RESET;
      vc2_ff     <= PLAIN_RESET;
    end
    else
    begin
      if (wr_hit(ADDR_NEG_ADVERTISE))
        adv_ff <= reg_wdata;
      if (wr_hit(ADDR_NEG_NEXT_PAGE))
        np_ff <= reg_wdata;
      if (wr_hit(ADDR_MAC_IF_CONTROL))
        mac_ctl_ff <= reg_wdata;
      if (wr_hit(ADDR_IRQ_CONTROL_STATUS))
        irq_ff <= reg_wdata;
      if (wr_hit(ADDR_VENDOR_CONTROL_ONE))
        vc1_ff <= reg_wdata;
      if (wr_hit(ADDR_VENDOR_CONTROL_TWO))
        vc2_ff <= reg_wdata;
    end
  end

  // Receive error tally saturates rather than wrapping, and counting stops in power-down.
  always_ff @(posedge mclk)
  begin
    if (any_reset)
      err_cnt_ff <= PLAIN_RESET;
    else if (rx_error_event && func_enable && err_cnt_ff != 16'hffff)
      err_cnt_ff <= err_cnt_ff + 16'h0001;
  end

  // Read data is registered; reserved addresses return zero.
  always_ff @(posedge mclk)
  begin
    if (srst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      case (reg_addr)  // RULE_14
        ADDR_BASIC_CONTROL:
          reg_rdata <= {soft_busy, ctrl_ff[14:10], restart_ff, ctrl_ff[8:0]};  // RULE_01
        ADDR_BASIC_STATUS:
        begin
          reg_rdata                  <= STATUS_FIXED;
          reg_rdata[STATUS_NEG_DONE] <= neg_done;
          reg_rdata[STATUS_LINK]     <= link_up;
        end
        ADDR_IDENTIFIER_HIGH:    reg_rdata <= ID_HIGH_VALUE;
        ADDR_IDENTIFIER_LOW:     reg_rdata <= ID_LOW_VALUE;
        ADDR_NEG_ADVERTISE:      reg_rdata <= adv_ff;
        ADDR_PARTNER_ABILITY:    reg_rdata <= partner_ability;
        ADDR_NEG_EXPANSION:      reg_rdata <= neg_expansion;
        ADDR_NEG_NEXT_PAGE:      reg_rdata <= np_ff;
        ADDR_PARTNER_NEXT_PAGE:  reg_rdata <= partner_next_page;
        ADDR_MAC_IF_CONTROL:     reg_rdata <= mac_ctl_ff;
        ADDR_RX_ERROR_TALLY:     reg_rdata <= err_cnt_ff;
        ADDR_IRQ_CONTROL_STATUS: reg_rdata <= irq_ff;
        ADDR_VENDOR_CONTROL_ONE: reg_rdata <= vc1_ff;
        ADDR_VENDOR_CONTROL_TWO: reg_rdata <= vc2_ff;
        default:                 reg_rdata <= 16'h0000;  // RULE_15
      endcase
    end
  end

  // Mode outputs; the management port above keeps working in power-down.
  always_comb
  begin
    phy_reset   = soft_busy;                                      // RULE_01
    neg_enable  = ctrl_ff[BIT_NEG_ENABLE] && !ctrl_ff[BIT_POWER_DOWN];  // RULE_04
    neg_restart = restart_ff;                                     // RULE_10
    // Negotiated outcome wins while enabled; manual bits apply otherwise.
    speed_100   = ctrl_ff[BIT_NEG_ENABLE] ? neg_speed_100 : ctrl_ff[BIT_SPEED];  // RULE_03
    full_duplex = ctrl_ff[BIT_NEG_ENABLE] ? neg_full_duplex
                                          : ctrl_ff[BIT_DUPLEX];  // RULE_11
    loopback_en = ctrl_ff[BIT_LOOPBACK];                          // RULE_02
    power_down  = ctrl_ff[BIT_POWER_DOWN];                        // RULE_07
    func_enable = !ctrl_ff[BIT_POWER_DOWN];                       // RULE_08
    isolate_en  = ctrl_ff[BIT_ISOLATE];                           // RULE_09
    col_test_en = ctrl_ff[BIT_COL_TEST];                          // RULE_12
    tx_enable   = !ctrl_ff[BIT_TX_DISABLE] && !ctrl_ff[BIT_POWER_DOWN]
                  && !ctrl_ff[BIT_ISOLATE];                       // RULE_13
  end
endmodule

/* sim/pmr_mgmt_model.sv */
// Station management controller model that issues register accesses.
`timescale 1ns/1ns
module pmr_mgmt_model
(
  input  wire logic        mclk,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [4:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;

  // One strobe per access; released lines show inverted values so stale data never matches.
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    @(posedge mclk) #1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {wr, !wr, a, d};
    @(posedge mclk) #1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
    q = reg_rdata;
  endtask
endmodule

/* sim/pmr_regmap_checker.sv */
// Concurrent checks on the ports of the management register map.
`timescale 1ns/1ns
module pmr_regmap_checker
(
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        neg_speed_100,
  input  wire logic        neg_full_duplex,
  input  wire logic        phy_reset,
  input  wire logic        neg_enable,
  input  wire logic        neg_restart,
  input  wire logic        speed_100,
  input  wire logic        full_duplex,
  input  wire logic        loopback_en,
  input  wire logic        power_down,
  input  wire logic        func_enable,
  input  wire logic        isolate_en,
  input  wire logic        col_test_en,
  input  wire logic        tx_enable
);
  // Control writes count only outside a soft reset, which overrides them.
  wire ctl_wr = reg_wr && reg_addr == 5'h00 && !phy_reset;
  wire quiet  = ctl_wr && !reg_wdata[15];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sr_start_a: assert property (ctl_wr && reg_wdata[15] |=> phy_reset)
    else $error("soft reset did not start");
  sr_len_a: assert property ($rose(phy_reset) |-> phy_reset[*4] ##1 !phy_reset)
    else $error("soft reset length wrong");
  rs_pulse_a: assert property (quiet && reg_wdata[9] |=> neg_restart ##1 !neg_restart)
    else $error("restart pulse wrong");
  mode_bits_a: assert property (quiet |=> {loopback_en, power_down, isolate_en, col_test_en,
    neg_enable} == $past({reg_wdata[14], reg_wdata[11:10], reg_wdata[7],
    reg_wdata[12] & !reg_wdata[11]}))
    else $error("mode outputs differ from write");
  manual_mode_a: assert property (quiet && !reg_wdata[12] |=>
    {speed_100, full_duplex} == $past({reg_wdata[13], reg_wdata[8]}))
    else $error("manual speed or duplex wrong");
  neg_win_a: assert property (neg_enable |->
    speed_100 == neg_speed_100 && full_duplex == neg_full_duplex)
    else $error("negotiated mode not applied");
  tx_gate_a: assert property (quiet |=> tx_enable == !$past(|reg_wdata[11:10] | reg_wdata[0]))
    else $error("transmitter enable wrong");
  pd_func_a: assert property (power_down |-> !func_enable && !neg_enable && !tx_enable)
    else $error("functions on in power-down");
  rsv_bits_a: assert property (reg_rd && reg_addr == 5'h00 |=> reg_rdata[6:1] == 6'h00)
    else $error("reserved control bits not zero");

  cover property ($fell(phy_reset));
  cover property (neg_restart);
  cover property (power_down && reg_rd);
endmodule

bind pmr_regmap pmr_regmap_checker u_chk (.*);

/* sim/tb.sv */
// Self-checking bench for the management register map.
`timescale 1ns/1ns
module tb;
  import pmr_pkg::*;
  logic        mclk = 0, srst = 1, rx_error_event = 0, reg_wr, reg_rd;
  logic        speed_strap, autoneg_strap_input, isolate_strap, duplex_strap;
  logic        neg_done, neg_speed_100, neg_full_duplex, link_up, phy_reset;
  logic        neg_enable, neg_restart, speed_100, full_duplex, loopback_en;
  logic        power_down, func_enable, isolate_en, col_test_en, tx_enable;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, partner_ability, neg_expansion, partner_next_page, q, w;
  int          bad_count = 0, total_checks = 0, n;
  logic [4:0]  wr_addrs [6] = '{ADDR_NEG_ADVERTISE, ADDR_NEG_NEXT_PAGE, ADDR_MAC_IF_CONTROL,
                                ADDR_IRQ_CONTROL_STATUS, ADDR_VENDOR_CONTROL_ONE,
                                ADDR_VENDOR_CONTROL_TWO};
  wire  [8:0]  outs = {loopback_en, power_down, isolate_en, col_test_en, neg_enable,
                       speed_100, full_duplex, tx_enable, func_enable};

  pmr_regmap DUT (.*);
  pmr_mgmt_model u_mgmt (.*);

  initial forever #2 mclk = !mclk;

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Control value implied by the strap levels; duplex takes the inverted strap.
  function automatic logic [15:0] ctrl_default();
    return {2'b00, speed_strap, autoneg_strap_input, 1'b0, isolate_strap, 1'b0,
            !duplex_strap, 8'h00};
  endfunction

  // Contents of every other address after reset and the three error events; gaps in the map read zero.
  function automatic logic [15:0] exp_reg(input logic [4:0] a);
    case (a)
      5'h01: return (STATUS_FIXED & 16'hffdb) | {10'h000, neg_done, 2'b00, link_up, 2'b00};
      5'h02: return ID_HIGH_VALUE;
      5'h03: return ID_LOW_VALUE;
      5'h05: return partner_ability;
      5'h06: return neg_expansion;
      5'h08: return partner_next_page;
      5'h15: return 16'h0003;
      5'h04, 5'h07, 5'h14, 5'h1b, 5'h1e, 5'h1f: return PLAIN_RESET;
      default: return 16'h0000;
    endcase
  endfunction

  // Mode outputs implied by a control word; negotiation overrides speed and duplex.
  function automatic logic [8:0] exp_outs(input logic [15:0] v);
    return {v[14], v[11], v[10], v[7], v[12] & !v[11], v[12] ? neg_speed_100 : v[13],
            v[12] ? neg_full_duplex : v[8], !(v[0] | v[10] | v[11]), !v[11]};
  endfunction

  initial
  begin
    n = $urandom(62539);
    {speed_strap, autoneg_strap_input, isolate_strap, duplex_strap} = 4'($urandom);
    {neg_done, neg_speed_100, neg_full_duplex, link_up} = 4'($urandom);
    {partner_ability, neg_expansion} = 32'($urandom);
    partner_next_page = 16'($urandom);
    repeat (2) @(posedge mclk);
    #1 srst = 0;
    check(16'(outs), 16'(exp_outs(ctrl_default())));
    // Three error events feed the tally before the address sweep.
    repeat (3)
    begin
      @(posedge mclk) #1 rx_error_event = 1;
      @(posedge mclk) #1 rx_error_event = 0;
    end
    for (int a = 0; a < 32; a++)
    begin
      if (!(a inside {0, 4, 7, 20, 27, 30, 31}))
        u_mgmt.xfer(1, 5'(a), 16'hffff, q);
      u_mgmt.xfer(0, 5'(a), 16'h0000, q);
      check(q, a == 0 ? ctrl_default() : exp_reg(5'(a)));
    end
    // Writable registers other than control keep whatever word is written.
    for (int k = 0; k < 6; k++)
    begin
      w = 16'($urandom);
      u_mgmt.xfer(1, wr_addrs[k], w, q);
      u_mgmt.xfer(0, wr_addrs[k], 16'h0000, q);
      check(q, w);
    end
    // Corner words first, then random ones; restart never reads back once settled.
    for (int i = 0; i < 40; i++)
    begin
      w = i == 0 ? 16'h7fff : i == 1 ? 16'h0000 : i == 2 ? 16'h4a81 : 16'($urandom) & 16'h7fff;
      {neg_speed_100, neg_full_duplex} = 2'($urandom);
      u_mgmt.xfer(1, 5'h00, w, q);
      u_mgmt.xfer(0, 5'h00, 16'h0000, q);
      check(q, w & CTRL_WRITE_MASK & 16'h7dff);
      check(16'(outs), 16'(exp_outs(w)));
    end
    u_mgmt.xfer(1, 5'h00, 16'hc981, q);
    n = 0;
    while (phy_reset === 1'b1 && n < 20)
    begin
      n++;
      @(posedge mclk) #1;
    end
    check(16'(n), 16'(SOFT_RESET_CYCLES));
    u_mgmt.xfer(0, 5'h00, 16'h0000, q);
    check(q, ctrl_default());
    // The soft reset must also have cleared the other writable registers and the tally.
    for (int k = 0; k < 6; k++)
    begin
      u_mgmt.xfer(0, wr_addrs[k], 16'h0000, q);
      check(q, PLAIN_RESET);
    end
    u_mgmt.xfer(0, ADDR_RX_ERROR_TALLY, 16'h0000, q);
    check(q, PLAIN_RESET);
    end_sim();
  end
endmodule
